// ==== inc/tlip_arb_if.sv ====
// Pending requests and the winner between top and arbiter.
`timescale 1ns/1ps
interface tlip_arb_if;
  tlip_pkg::tlip_srcvec_t pend_hi;
  tlip_pkg::tlip_srcvec_t pend_lo;
  logic                   win_valid;
  logic                   win_hi;
  logic [3:0]             win_idx;
  modport ctl (output pend_hi, output pend_lo,
               input win_valid, input win_hi, input win_idx);
  modport arb (input pend_hi, input pend_lo,
               output win_valid, output win_hi, output win_idx);
endinterface

// ==== inc/tlip_map.svh ====
// Register offsets, bit positions, reset values and vectors of the prioritiser.
`ifndef TLIP_MAP_SVH
`define TLIP_MAP_SVH

`define TLIP_NSRC          11
`define TLIP_IDXW          4
`define TLIP_OFS_ENABLE    12'h2a0
`define TLIP_OFS_AUX       12'h2a4
`define TLIP_OFS_LEVEL     12'h2e0
`define TLIP_OFS_STATUS    12'h300
`define TLIP_RST_ENABLE    8'h00
`define TLIP_RST_LEVEL     8'h00
`define TLIP_RST_AUX       8'ha0
`define TLIP_LEVEL_WMASK   8'h7f

`define TLIP_EN_GATE       7
`define TLIP_EN_CONV       6
`define TLIP_EN_CTR2       5
`define TLIP_EN_UART       4
`define TLIP_EN_CTR1       3
`define TLIP_EN_EXT1       2
`define TLIP_EN_CTR0       1
`define TLIP_EN_EXT0       0
`define TLIP_AUX_TIC_LVL   6
`define TLIP_AUX_SUP_LVL   5
`define TLIP_AUX_SER_LVL   4
`define TLIP_AUX_TIC_ON    2
`define TLIP_AUX_SUP_ON    1
`define TLIP_AUX_SER_ON    0

`define TLIP_SRC_WDOG      1
`define TLIP_SRC_EXT0      2

`define TLIP_VEC_SUPMON    16'h0043
`define TLIP_VEC_WDOG      16'h005b
`define TLIP_VEC_EXT0      16'h0003
`define TLIP_VEC_CONV      16'h0033
`define TLIP_VEC_CTR0      16'h000b
`define TLIP_VEC_EXT1      16'h0013
`define TLIP_VEC_CTR1      16'h001b
`define TLIP_VEC_SERIAL    16'h003b
`define TLIP_VEC_UART      16'h0023
`define TLIP_VEC_CTR2      16'h002b
`define TLIP_VEC_TIC       16'h0053

`endif

// ==== inc/tlip_pkg.sv ====
// Types shared by the prioritiser modules.
package tlip_pkg;
  typedef enum logic [1:0] {
    TLIP_IDLE = 2'b00,
    TLIP_PUSH = 2'b01,
    TLIP_LOAD = 2'b10
  } tlip_state_t;
  typedef logic [10:0] tlip_srcvec_t;
endpackage

// ==== src/tlip_arbiter.sv ====
// Level-then-poll-order arbiter over the pending sources.
`timescale 1ns/1ps
`include "tlip_map.svh"
module tlip_arbiter (
  tlip_arb_if.arb a
);
  // Index order is the polling order, so the lowest set index wins.
  always_comb begin
    a.win_valid = 1'b0;
    a.win_hi    = 1'b0;
    a.win_idx   = '0;
    if (|a.pend_hi) begin
      a.win_valid = 1'b1;
      a.win_hi    = 1'b1;
      for (int i = `TLIP_NSRC - 1; i >= 0; i--) begin
        if (a.pend_hi[i]) begin
          a.win_idx = 4'(i);
        end
      end
    end else if (|a.pend_lo) begin
      a.win_valid = 1'b1;
      for (int i = `TLIP_NSRC - 1; i >= 0; i--) begin
        if (a.pend_lo[i]) begin
          a.win_idx = 4'(i);
        end
      end
    end
  end
endmodule

// ==== src/tlip_top.sv ====
// Two-level interrupt prioritiser with its AHB-Lite register slave.
//
// Summary of operation
// - Aux bits 2,1,0 enable tic, supmon, serial.
// - Aux bits 6,5,4 pick their priority level.
// - High request preempts a low service routine.
// - Same-cycle high request served before low.
// - Equal level never preempts; waits for return.
// - Equal level requests follow fixed polling order.
// - Accept pushes program counter, then loads vector.
// - Each source has its fixed vector address.
// - Global gate bit blocks or allows all sources.
// - Priority bit one means high, zero low.
//
// Register access over AHB-Lite and the address map were left to the implementer.
`timescale 1ns/1ps
`include "tlip_map.svh"
module tlip_top (
  input  wire logic                   mclk,
  input  wire logic                   rst,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic      [31:0]            hrdata_q,
  output logic                        hreadyout_q,
  output logic                        hresp_q,
  input  wire tlip_pkg::tlip_srcvec_t src_flags,
  input  wire logic                   core_boundary,
  input  wire logic                   core_reti,
  output logic                        push_pc_q,
  output logic                        load_pc_q,
  output logic      [15:0]            vector_q,
  output logic                        in_service_hi_q,
  output logic                        in_service_lo_q
);
  logic [7:0]             enable_q;
  logic [7:0]             level_q;
  logic [7:0]             aux_q;
  logic                   wr_pend_q;
  logic [11:0]            wr_addr_q;
  logic [3:0]             cur_idx_q;
  tlip_pkg::tlip_state_t  state_q;
  tlip_pkg::tlip_srcvec_t src_en;
  tlip_pkg::tlip_srcvec_t src_lvl;
  tlip_pkg::tlip_srcvec_t req;
  logic                   gate;
  logic                   accept;
  logic                   addr_ok;
  logic [31:0]            rd_val;
  logic [2:0]             unused_hsize;

  tlip_arb_if arb_bus ();

  tlip_arbiter u_tlip_arbiter (
    .a (arb_bus.arb)
  );

  assign unused_hsize = hsize;

  function automatic logic [15:0] vec_of(input logic [3:0] idx);
    case (idx)
      4'h0:    vec_of = `TLIP_VEC_SUPMON;
      4'h1:    vec_of = `TLIP_VEC_WDOG;
      4'h2:    vec_of = `TLIP_VEC_EXT0;
      4'h3:    vec_of = `TLIP_VEC_CONV;
      4'h4:    vec_of = `TLIP_VEC_CTR0;
      4'h5:    vec_of = `TLIP_VEC_EXT1;
      4'h6:    vec_of = `TLIP_VEC_CTR1;
      4'h7:    vec_of = `TLIP_VEC_SERIAL;
      4'h8:    vec_of = `TLIP_VEC_UART;
      4'h9:    vec_of = `TLIP_VEC_CTR2;
      default: vec_of = `TLIP_VEC_TIC;
    endcase
  endfunction

  // Enables and levels gathered in polling order.
  // The watchdog has no enable bit and is always high level.
  assign src_en = {aux_q[`TLIP_AUX_TIC_ON],
                   enable_q[`TLIP_EN_CTR2],
                   enable_q[`TLIP_EN_UART],
                   aux_q[`TLIP_AUX_SER_ON],
                   enable_q[`TLIP_EN_CTR1],
                   enable_q[`TLIP_EN_EXT1],
                   enable_q[`TLIP_EN_CTR0],
                   enable_q[`TLIP_EN_CONV],
                   enable_q[`TLIP_EN_EXT0],
                   1'b1,
                   aux_q[`TLIP_AUX_SUP_ON]};
  assign src_lvl = {aux_q[`TLIP_AUX_TIC_LVL],
                    level_q[`TLIP_EN_CTR2],
                    level_q[`TLIP_EN_UART],
                    aux_q[`TLIP_AUX_SER_LVL],
                    level_q[`TLIP_EN_CTR1],
                    level_q[`TLIP_EN_EXT1],
                    level_q[`TLIP_EN_CTR0],
                    level_q[`TLIP_EN_CONV],
                    level_q[`TLIP_EN_EXT0],
                    1'b1,
                    aux_q[`TLIP_AUX_SUP_LVL]};
  assign gate = enable_q[`TLIP_EN_GATE];
  assign req  = src_flags & src_en & {`TLIP_NSRC{gate}};

  // A high request is held off only by a high routine; a low one by either.
  assign arb_bus.pend_hi = req & src_lvl &
                           {`TLIP_NSRC{~in_service_hi_q}};
  assign arb_bus.pend_lo = req & ~src_lvl &
                           {`TLIP_NSRC{~(in_service_hi_q |
                                         in_service_lo_q)}};
  assign accept = (state_q == tlip_pkg::TLIP_IDLE) && core_boundary &&
                  arb_bus.win_valid;

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q   <= tlip_pkg::TLIP_IDLE;
      push_pc_q <= 1'b0;
      load_pc_q <= 1'b0;
    end else begin
      push_pc_q <= 1'b0;
      load_pc_q <= 1'b0;
      case (state_q)
        tlip_pkg::TLIP_IDLE: begin
          if (accept) begin
            state_q   <= tlip_pkg::TLIP_PUSH;
            push_pc_q <= 1'b1;
          end
        end
        tlip_pkg::TLIP_PUSH: begin
          state_q   <= tlip_pkg::TLIP_LOAD;
          load_pc_q <= 1'b1;
        end
        tlip_pkg::TLIP_LOAD: begin
          state_q <= tlip_pkg::TLIP_IDLE;
        end
        default: begin
          state_q <= tlip_pkg::TLIP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cur_idx_q <= '0;
      vector_q  <= '0;
    end else if (accept) begin
      cur_idx_q <= arb_bus.win_idx;
      vector_q  <= vec_of(arb_bus.win_idx);
    end
  end

  // A return always ends the innermost routine, which is the high one
  // whenever both levels are in service.
  always_ff @(posedge mclk) begin
    if (rst) begin
      in_service_hi_q <= 1'b0;
      in_service_lo_q <= 1'b0;
    end else begin
      if (core_reti) begin
        if (in_service_hi_q) begin
          in_service_hi_q <= 1'b0;
        end else begin
          in_service_lo_q <= 1'b0;
        end
      end
      // Placed after the return so that a same-cycle acceptance wins.
      if (accept) begin
        if (arb_bus.win_hi) begin
          in_service_hi_q <= 1'b1;
        end else begin
          in_service_lo_q <= 1'b1;
        end
      end
    end
  end

  // Bus slave: zero wait states, always OKAY, unmapped reads give zero.
  assign addr_ok = hsel && htrans[1] && hready;

  always_comb begin
    rd_val = '0;
    case (haddr[11:0])
      `TLIP_OFS_ENABLE: rd_val[7:0] = enable_q;
      `TLIP_OFS_LEVEL:  rd_val[7:0] = level_q;
      `TLIP_OFS_AUX:    rd_val[7:0] = aux_q;
      `TLIP_OFS_STATUS: rd_val = {14'h0000, in_service_hi_q,
                                  in_service_lo_q, 5'h00, req};
      default:          rd_val = '0;
    endcase
    // A read right behind a write to the same word sees the new value.
    if (wr_pend_q && wr_addr_q == haddr[11:0] &&
        (wr_addr_q == `TLIP_OFS_ENABLE || wr_addr_q == `TLIP_OFS_AUX)) begin
      rd_val = {24'h00_0000, hwdata[7:0]};
    end
    if (wr_pend_q && wr_addr_q == haddr[11:0] &&
        wr_addr_q == `TLIP_OFS_LEVEL) begin
      rd_val = {24'h00_0000, hwdata[7:0] & `TLIP_LEVEL_WMASK};
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_pend_q   <= 1'b0;
      wr_addr_q   <= '0;
      hrdata_q    <= '0;
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end else begin
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
      wr_pend_q   <= addr_ok && hwrite;
      if (addr_ok) begin
        wr_addr_q <= haddr[11:0];
      end
      if (addr_ok && !hwrite) begin
        hrdata_q <= rd_val;
      end
    end
  end

  // Software keeps aux bit 3 at zero; bits 3 and 7 are only stored.
  always_ff @(posedge mclk) begin
    if (rst) begin
      enable_q <= `TLIP_RST_ENABLE;
      level_q  <= `TLIP_RST_LEVEL;
      aux_q    <= `TLIP_RST_AUX;
    end else if (wr_pend_q) begin
      case (wr_addr_q)
        `TLIP_OFS_ENABLE: enable_q <= hwdata[7:0];
        `TLIP_OFS_LEVEL:  level_q  <= hwdata[7:0] &
                                      `TLIP_LEVEL_WMASK;
        `TLIP_OFS_AUX:    aux_q    <= hwdata[7:0];
        default: begin
        end
      endcase
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  push_load_seq_a: assert property (push_pc_q |=> load_pc_q && !push_pc_q)
    else $error("vector load did not follow the push");
  vector_value_a: assert property (load_pc_q |->
      vector_q == vec_of(cur_idx_q) && $past(push_pc_q))
    else $error("wrong vector address");
  same_level_a: assert property (accept |->
      !in_service_hi_q && (arb_bus.win_hi || !in_service_lo_q))
    else $error("equal level preempted a routine");
  high_first_a: assert property (accept && |(req & src_lvl) &&
      !in_service_hi_q |-> arb_bus.win_hi)
    else $error("low request served before high");
  poll_order_a: assert property (accept |->
      ((arb_bus.win_hi ? arb_bus.pend_hi : arb_bus.pend_lo) &
       ((11'h001 << arb_bus.win_idx) - 11'h001)) == 11'h000)
    else $error("polling order broken");
  gate_block_a: assert property (!gate |-> !accept ##1 !push_pc_q)
    else $error("accepted with global gate closed");
  enable_need_a: assert property (accept |->
      src_en[arb_bus.win_idx] && src_flags[arb_bus.win_idx])
    else $error("disabled source accepted");
  aux_enable_a: assert property (!aux_q[`TLIP_AUX_TIC_ON] |->
      !req[`TLIP_NSRC - 1])
    else $error("time interval request while disabled");
  level_track_a: assert property (accept && !arb_bus.win_hi |=>
      in_service_lo_q && push_pc_q)
    else $error("low level acceptance not recorded");
  preempt_a: assert property (in_service_lo_q && !in_service_hi_q &&
      !core_reti && accept && arb_bus.win_hi |=>
      in_service_hi_q && in_service_lo_q)
    else $error("high request failed to nest");
  wdog_tie_a: assert property (accept &&
      arb_bus.pend_hi[`TLIP_SRC_WDOG] |-> arb_bus.win_idx != 4'h2)
    else $error("external 0 beat the watchdog");

  nested_c: cover property (in_service_lo_q ##1 in_service_hi_q);
  low_accept_c: cover property (accept && !arb_bus.win_hi);
  reti_c: cover property (core_reti && in_service_hi_q);
  wait_same_c: cover property (in_service_lo_q && |arb_bus.win_valid == 0
      && |(req & ~src_lvl));
endmodule

// ==== tb/tlip_core_model.sv ====
// Behavioural core: offers interrupt boundaries and tracks the PC and stack.
`timescale 1ns/1ps
module tlip_core_model (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        allow,
  input  wire logic        slow,
  input  wire logic        reti_req,
  input  wire logic        push_pc_q,
  input  wire logic        load_pc_q,
  input  wire logic [15:0] vector_q,
  output logic             boundary,
  output logic             reti_q,
  output logic      [15:0] pc_q,
  output logic      [1:0]  depth_q
);
  logic tick_q;
  // A slow core reaches an instruction boundary only every other cycle.
  assign boundary = allow & (~slow | tick_q);
  always_ff @(posedge mclk) begin
    if (rst) tick_q <= 1'h0;
    else tick_q <= ~tick_q;
  end
  always_ff @(posedge mclk) begin
    if (rst) reti_q <= 1'h0;
    else reti_q <= reti_req;
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      pc_q    <= 16'h0000;
      depth_q <= 2'h0;
    end else begin
      if (load_pc_q) pc_q <= vector_q;
      depth_q <= depth_q + 2'(push_pc_q) - 2'(reti_q);
    end
  end
endmodule

// ==== tb/tlip_top_bench.sv ====
// Self-checking bench for the two-level interrupt prioritiser.
`timescale 1ns/1ps
`include "tlip_map.svh"
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
  failures++; $display("[ERR] %s expected %0h seen %0h", nm, ex, got); end end
module tlip_top_bench;
  logic                   mclk, rst, hsel, hwrite, allow, slow, reti_req;
  logic                   hready, hreadyout_q, hresp_q, push_pc_q, load_pc_q;
  logic                   boundary, reti_q, hi_q, lo_q;
  logic [1:0]             htrans, depth_q;
  logic [31:0]            haddr, hwdata, hrdata_q, rd;
  logic [15:0]            vector_q, pc_q;
  logic [15:0]            vec_tab [11];
  tlip_pkg::tlip_srcvec_t flags;
  int                     failures, n_compared, cycles;

  assign hready = hreadyout_q;
  always #2.5 mclk = ~mclk;

  tlip_top u_tlip_top (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hrdata_q(hrdata_q), .hreadyout_q(hreadyout_q),
    .hresp_q(hresp_q), .src_flags(flags), .core_boundary(boundary),
    .core_reti(reti_q), .push_pc_q(push_pc_q), .load_pc_q(load_pc_q),
    .vector_q(vector_q), .in_service_hi_q(hi_q), .in_service_lo_q(lo_q));
  tlip_core_model u_tlip_core_model (.mclk(mclk), .rst(rst), .allow(allow),
    .slow(slow), .reti_req(reti_req), .push_pc_q(push_pc_q),
    .load_pc_q(load_pc_q), .vector_q(vector_q), .boundary(boundary),
    .reti_q(reti_q), .pc_q(pc_q), .depth_q(depth_q));

  task automatic conclude();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      conclude();
    end
  end

  // One AHB-Lite single word transfer; the slave may stretch either phase.
  task automatic ahb(input logic w, input logic [11:0] a, input logic [7:0] d);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0_0000, a};
    do @(posedge mclk); while (hready !== 1'h1);
    htrans <= 2'h0;
    hwdata <= {24'h00_0000, d};
    do @(posedge mclk); while (hready !== 1'h1);
    rd = hrdata_q;
    `CHK("hresp", 1'h0, hresp_q)
  endtask

  task automatic chk_rd(input string nm, input logic [11:0] a,
                        input logic [31:0] ex);
    ahb(1'h0, a, 8'h00);
    `CHK(nm, ex, rd)
  endtask

  task automatic quiet(input int n);
    repeat (n) begin
      @(posedge mclk);
      `CHK("no accept", 1'h0, push_pc_q)
    end
  endtask

  // ex holds the level in bit 16 and the vector below it.
  task automatic take(input logic [17:0] ex);
    int k;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (push_pc_q !== 1'h1 && k < 20);
    `CHK("vector", ex[15:0], vector_q)
    `CHK("hi level", ex[16], hi_q)
    @(posedge mclk);
    `CHK("load after push", 1'h1, load_pc_q)
    @(posedge mclk);
    `CHK("pc loaded", ex[15:0], pc_q)
  endtask

  task automatic reti();
    reti_req <= 1'h1;
    @(posedge mclk);
    reti_req <= 1'h0;
    repeat (2) @(posedge mclk);
  endtask

  function automatic logic [10:0] pend(input logic [10:0] f,
                                       input logic [7:0] en, ax);
    return f & {11{en[7]}} & {ax[2], en[5], en[4], ax[0], en[3], en[2],
                              en[1], en[6], en[0], 1'h1, ax[1]};
  endfunction

  // Highest level first, then the lowest poll index within that level.
  function automatic logic [17:0] expect_win(input logic [10:0] f,
                                             input logic [7:0] en, lv, ax);
    logic [10:0] on;
    logic [10:0] hv;
    logic [17:0] r;
    on = pend(f, en, ax);
    hv = {ax[6], lv[5], lv[4], ax[4], lv[3], lv[2], lv[1], lv[6], lv[0],
          1'h1, ax[5]};
    r = '0;
    for (int i = 10; i >= 0; i--)
      if (on[i] && !hv[i]) r = {2'h2, vec_tab[i]};
    for (int i = 10; i >= 0; i--)
      if (on[i] && hv[i]) r = {2'h3, vec_tab[i]};
    return r;
  endfunction

  initial begin
    logic [7:0]  en, lv, ax;
    logic [10:0] f;
    logic [17:0] ex;
    {mclk, rst, hsel, hwrite, allow, slow, reti_req} = 7'h20;
    {htrans, haddr, hwdata, flags} = '0;
    {failures, n_compared, cycles} = '0;
    vec_tab = '{`TLIP_VEC_SUPMON, `TLIP_VEC_WDOG, `TLIP_VEC_EXT0,
      `TLIP_VEC_CONV, `TLIP_VEC_CTR0, `TLIP_VEC_EXT1, `TLIP_VEC_CTR1,
      `TLIP_VEC_SERIAL, `TLIP_VEC_UART, `TLIP_VEC_CTR2, `TLIP_VEC_TIC};
    void'($urandom(11));
    repeat (5) @(posedge mclk);
    rst <= 1'h0;
    @(posedge mclk);
    chk_rd("enable rst", `TLIP_OFS_ENABLE, 32'h0000_0000);
    chk_rd("level rst", `TLIP_OFS_LEVEL, 32'h0000_0000);
    chk_rd("aux rst", `TLIP_OFS_AUX, {24'h00_0000, `TLIP_RST_AUX});
    ahb(1'h1, `TLIP_OFS_AUX, 8'h77);
    chk_rd("aux rw", `TLIP_OFS_AUX, 32'h0000_0077);
    ahb(1'h1, `TLIP_OFS_LEVEL, 8'hff);
    chk_rd("level bit7", `TLIP_OFS_LEVEL, 32'h0000_007f);
    chk_rd("unmapped", 12'h004, 32'h0000_0000);
    // Nesting: low routine, same-level wait, high preemption, returns.
    ahb(1'h1, `TLIP_OFS_ENABLE, 8'h8d);
    ahb(1'h1, `TLIP_OFS_LEVEL, 8'h01);
    ahb(1'h1, `TLIP_OFS_AUX, 8'h00);
    flags <= 11'h020;
    allow <= 1'h1;
    take({2'h2, `TLIP_VEC_EXT1});
    flags <= 11'h040;
    quiet(8);
    flags <= 11'h044;
    take({2'h3, `TLIP_VEC_EXT0});
    `CHK("nested lo", 1'h1, lo_q)
    flags <= 11'h040;
    reti();
    `CHK("hi returned", 2'h1, {hi_q, lo_q})
    quiet(6);
    reti();
    take({2'h2, `TLIP_VEC_CTR1});
    flags <= 11'h000;
    reti();
    flags <= 11'h006;
    take({2'h3, `TLIP_VEC_WDOG});
    flags <= 11'h000;
    allow <= 1'h0;
    reti();
    `CHK("all returned", 2'h0, {hi_q, lo_q})
    for (int it = 0; it < 120; it++) begin
      en = 8'($urandom);
      en[7] = (it % 6 != 0);
      lv = 8'($urandom);
      ax = 8'($urandom) & 8'h77;
      f = 11'($urandom);
      ex = expect_win(f, en, lv, ax);
      ahb(1'h1, `TLIP_OFS_ENABLE, en);
      ahb(1'h1, `TLIP_OFS_LEVEL, lv);
      ahb(1'h1, `TLIP_OFS_AUX, ax);
      flags <= f;
      repeat (2) @(posedge mclk);
      chk_rd("pending", `TLIP_OFS_STATUS, 32'(pend(f, en, ax)));
      allow <= 1'h1;
      slow <= 1'($urandom);
      if (ex[17]) begin
        take(ex);
        `CHK("lo level", ~ex[16], lo_q)
        flags <= 11'h000;
        allow <= 1'h0;
        reti();
        `CHK("stack depth", 2'h0, depth_q)
      end else begin
        quiet(8);
        flags <= 11'h000;
        allow <= 1'h0;
      end
      @(posedge mclk);
    end
    conclude();
  end
endmodule
